// [adf_defines.svh]
// Constants for the front-end command host controller
`ifndef ADF_DEFINES_SVH
`define ADF_DEFINES_SVH
`define ADF_OPC_WAKE 8'h02
`define ADF_OPC_STANDBY 8'h04
`define ADF_OPC_RESET 8'h06
`define ADF_OPC_START 8'h08
`define ADF_OPC_STOP 8'h0A
`define ADF_OPC_OFFCAL 8'h1A
`define ADF_OPC_CONTINUOUS_READOUT_CMD 8'h10
`define ADF_OPC_HALT_CONTINUOUS_READOUT_CMD 8'h11
`define ADF_OPC_RDATA 8'h12
`define ADF_REGISTER_READ_CMD_PFX 3'h1
`define ADF_REGISTER_WRITE_CMD_PFX 3'h2
`define ADF_CNT_PFX 3'h0
`define ADF_FILL_BYTE 8'h00
`define ADF_REG_CH1SET 5'h04
`define ADF_REG_CH2SET 5'h05
`define ADF_REG_RESPIRATION_CONTROL_TWO 5'h0A
`define ADF_CALIB_BIT 7
`define ADF_RESULT_BYTES 6'h09
`define ADF_OPC_BYTES_ONE 2'h1
`define ADF_OPC_BYTES_TWO 2'h2
`define ADF_SYS_PERIOD_NS 10
`define ADF_MCLK_PERIOD_NS 1954
`define ADF_DECODE_TCLK 4
`define ADF_KEEPOUT_TCLK 4
`define ADF_UPDATE_TCLK 4
`define ADF_RESET_TMOD 9
`define ADF_TMOD_TCLK 4
`define ADF_CYC(t) \
  ((((t) * `ADF_MCLK_PERIOD_NS) + `ADF_SYS_PERIOD_NS - 1) / `ADF_SYS_PERIOD_NS)
`define ADF_DECODE_CYC 16'(`ADF_CYC(`ADF_DECODE_TCLK))
`define ADF_KEEPOUT_CYC 16'(`ADF_CYC(`ADF_KEEPOUT_TCLK))
`define ADF_UPDATE_CYC 16'(`ADF_CYC(`ADF_UPDATE_TCLK))
`define ADF_RESET_CYC `ADF_CYC(`ADF_RESET_TMOD * `ADF_TMOD_TCLK)
`define ADF_SCLK_HALF 4'h8
`define ADF_LAST_BIT 3'h7
`define ADF_RESULT_READY_N_IDLE 1'b1
`endif

// [adf_pkg.sv]
// Types for the front-end command host controller
package adf_pkg;
  typedef enum logic [4:0] {
    ADF_ST_IDLE = 5'h01,
    ADF_ST_SEND = 5'h02,
    ADF_ST_GAP = 5'h04,
    ADF_ST_WAIT_WR = 5'h08,
    ADF_ST_WAIT_RESULT_READY_N = 5'h10
  } adf_state_e;
  typedef enum logic [3:0] {
    ADF_OP_WAKE = 4'h0,
    ADF_OP_STANDBY = 4'h1,
    ADF_OP_RESET = 4'h2,
    ADF_OP_START = 4'h3,
    ADF_OP_STOP = 4'h4,
    ADF_OP_OFFCAL = 4'h5,
    ADF_OP_CONTINUOUS_READOUT_CMD = 4'h6,
    ADF_OP_HALT_CONTINUOUS_READOUT_CMD = 4'h7,
    ADF_OP_RDATA = 4'h8,
    ADF_OP_REGISTER_READ_CMD = 4'h9,
    ADF_OP_REGISTER_WRITE_CMD = 4'hA,
    ADF_OP_AUTO = 4'hF
  } adf_op_e;
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } adf_sync_s;
  typedef struct packed {
    logic busy;
    logic high;
    logic sclk;
    logic mosi;
    logic done;
    logic [7:0] sh;
    logic [7:0] rx;
    logic [2:0] bit_cnt;
    logic [3:0] ph_cnt;
  } adf_byte_s;
  typedef struct packed {
    adf_state_e state;
    adf_op_e op;
    logic [4:0] addr;
    logic [4:0] cnt;
    logic [5:0] byte_idx;
    logic [5:0] total;
    logic [1:0] opc_bytes;
    logic [7:0] tx;
    logic eng_start;
    logic [15:0] gap_cnt;
    logic cs_n;
    logic cmd_ready;
    logic wr_ready;
    logic [7:0] rd_data;
    logic rd_valid;
    logic rd_last;
    logic done;
    logic error;
    logic standby;
    logic cont;
    logic running;
    logic calib_en;
    logic cal_need;
    logic result_ready_n_prev;
    logic fall_pend;
    logic [15:0] since_edge;
    logic start_pin;
  } adf_host_s;
endpackage

// [adf_sync3.sv]
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module adf_sync3
  import adf_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
)(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic d_in,
  output logic q_out
);
  adf_sync_s st_reg;
  adf_sync_s st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = d_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if (st_reg.s2 == st_reg.s3)
    begin
      st_next.q = st_reg.s3;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_reg <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign q_out = st_reg.q;
endmodule

// [adf_spi_byte.sv]
// Serial byte engine: clock idles low, data set on rising, sampled late
`timescale 1ns/1ps
`include "adf_defines.svh"
module adf_spi_byte
  import adf_pkg::*;
(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [7:0] tx_in,
  input wire logic miso_in,
  output logic sclk_out,
  output logic mosi_out,
  output logic done_out,
  output logic [7:0] rx_out
);
  adf_byte_s st_reg;
  adf_byte_s st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (start_in && !st_reg.busy)
    begin
      st_next.busy = 1'b1;
      st_next.high = 1'b1;
      st_next.sclk = 1'b1;
      st_next.mosi = tx_in[7];
      st_next.sh = {tx_in[6:0], 1'b0};
      st_next.bit_cnt = 3'h0;
      st_next.ph_cnt = 4'h0;
    end
    else if (st_reg.busy)
    begin
      st_next.ph_cnt = st_reg.ph_cnt + 4'h1;
      if (st_reg.ph_cnt == `ADF_SCLK_HALF - 4'h1)
      begin
        st_next.ph_cnt = 4'h0;
        if (st_reg.high)
        begin
          st_next.sclk = 1'b0;
          st_next.high = 1'b0;
        end
        else
        begin
          // Sample a full period after the device changed its output
          st_next.rx = {st_reg.rx[6:0], miso_in};
          if (st_reg.bit_cnt == `ADF_LAST_BIT)
          begin
            st_next.busy = 1'b0;
            st_next.done = 1'b1;
          end
          else
          begin
            st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
            st_next.sclk = 1'b1;
            st_next.high = 1'b1;
            st_next.mosi = st_reg.sh[7];
            st_next.sh = {st_reg.sh[6:0], 1'b0};
          end
        end
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign sclk_out = st_reg.sclk;
  assign mosi_out = st_reg.mosi;
  assign done_out = st_reg.done;
  assign rx_out = st_reg.rx;
endmodule

// [adf_host_ctrl.sv]
// Host controller that drives the front end's serial command pins
// Functional notes
// - After wake, wait four master clocks before the next byte.
// - In standby send only the wake command.
// - After reset send nothing for nine modulator clocks.
// - Leave four master clocks between start and a following stop.
// - Hold the start pin low while conversions run by command.
// - Set calibration enable before offset cancel; redo after gain change.
// - In continuous readout, send halt before any other command.
// - After continuous readout command, wait four master clocks.
// - No continuous readout command within four clocks of data ready.
// - Do not clock out results during the output update interval.
// - After halting continuous readout, wait four master clocks.
// - Send single read after data ready falls; no wait afterwards.
// - Ensure conversions run before reading results in either mode.
// - Separate bytes of multi-byte commands by four master clocks; the code gaps only after the two opcode bytes of register commands.
// - Register write: 010+address, count-1, data MSB first, select low.
`timescale 1ns/1ps
`include "adf_defines.svh"
module adf_host_ctrl
  import adf_pkg::*;
#(
  parameter int RESET_WAIT_CYC = `ADF_RESET_CYC
)(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic cmd_valid_in,
  input wire logic [3:0] cmd_code_in,
  input wire logic [4:0] cmd_addr_in,
  input wire logic [4:0] cmd_count_in,
  input wire logic wr_valid_in,
  input wire logic [7:0] wr_data_in,
  input wire logic miso_in,
  input wire logic result_ready_n_in,
  output logic cmd_ready_out,
  output logic wr_ready_out,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  output logic rd_last_out,
  output logic done_out,
  output logic error_out,
  output logic standby_out,
  output logic cont_mode_out,
  output logic running_out,
  output logic cal_needed_out,
  output logic cs_n_out,
  output logic sclk_out,
  output logic mosi_out,
  output logic start_pin_out
);
  adf_host_s st_reg;
  adf_host_s st_next;
  logic miso_s;
  logic result_ready_n_s;
  logic eng_done;
  logic [7:0] eng_rx;
  logic result_ready_n_fall;
  logic result_ready_n_edge;
  logic go_read;
  logic refuse;
  adf_op_e op_in;
  logic [5:0] data_idx;
  logic [4:0] wr_addr;

  adf_sync3 #(
    .RESET_VAL(1'b0)
  ) u_miso_sync (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .d_in(miso_in),
    .q_out(miso_s)
  );

  adf_sync3 #(
    .RESET_VAL(`ADF_RESULT_READY_N_IDLE)
  ) u_result_ready_n_sync (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .d_in(result_ready_n_in),
    .q_out(result_ready_n_s)
  );

  adf_spi_byte u_byte (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .start_in(st_reg.eng_start),
    .tx_in(st_reg.tx),
    .miso_in(miso_s),
    .sclk_out(sclk_out),
    .mosi_out(mosi_out),
    .done_out(eng_done),
    .rx_out(eng_rx)
  );

  // First byte on the wire for each command
  function automatic logic [7:0] first_byte(adf_op_e op, logic [4:0] addr);
    logic [7:0] b;
    b = `ADF_FILL_BYTE;
    case (op)
      ADF_OP_WAKE: b = `ADF_OPC_WAKE;
      ADF_OP_STANDBY: b = `ADF_OPC_STANDBY;
      ADF_OP_RESET: b = `ADF_OPC_RESET;
      ADF_OP_START: b = `ADF_OPC_START;
      ADF_OP_STOP: b = `ADF_OPC_STOP;
      ADF_OP_OFFCAL: b = `ADF_OPC_OFFCAL;
      ADF_OP_CONTINUOUS_READOUT_CMD: b = `ADF_OPC_CONTINUOUS_READOUT_CMD;
      ADF_OP_HALT_CONTINUOUS_READOUT_CMD: b = `ADF_OPC_HALT_CONTINUOUS_READOUT_CMD;
      ADF_OP_RDATA: b = `ADF_OPC_RDATA;
      ADF_OP_REGISTER_READ_CMD: b = {`ADF_REGISTER_READ_CMD_PFX, addr};
      ADF_OP_REGISTER_WRITE_CMD: b = {`ADF_REGISTER_WRITE_CMD_PFX, addr};
      default: b = `ADF_FILL_BYTE;
    endcase
    return b;
  endfunction

  assign op_in = adf_op_e'(cmd_code_in);
  assign result_ready_n_fall = st_reg.result_ready_n_prev && !result_ready_n_s;
  assign result_ready_n_edge = st_reg.result_ready_n_prev != result_ready_n_s;
  assign data_idx = st_reg.byte_idx - 6'(st_reg.opc_bytes);
  assign wr_addr = st_reg.addr + data_idx[4:0];
  // Result ready and the update interval has passed
  assign go_read = st_reg.fall_pend &&
    (st_reg.since_edge >= `ADF_UPDATE_CYC);

  always_comb
  begin
    refuse = 1'b0;
    case (op_in)
      ADF_OP_WAKE, ADF_OP_STANDBY, ADF_OP_RESET, ADF_OP_START,
      ADF_OP_STOP, ADF_OP_OFFCAL, ADF_OP_CONTINUOUS_READOUT_CMD, ADF_OP_HALT_CONTINUOUS_READOUT_CMD,
      ADF_OP_RDATA, ADF_OP_REGISTER_READ_CMD, ADF_OP_REGISTER_WRITE_CMD: refuse = 1'b0;
      default: refuse = 1'b1;
    endcase
    if (st_reg.standby && op_in != ADF_OP_WAKE)
    begin
      refuse = 1'b1;
    end
    if (st_reg.cont && op_in != ADF_OP_HALT_CONTINUOUS_READOUT_CMD)
    begin
      refuse = 1'b1;
    end
    if (op_in == ADF_OP_OFFCAL && !st_reg.calib_en)
    begin
      refuse = 1'b1;
    end
    if ((op_in == ADF_OP_RDATA || op_in == ADF_OP_CONTINUOUS_READOUT_CMD) &&
        !st_reg.running)
    begin
      refuse = 1'b1;
    end
  end

  always_comb
  begin
    st_next = st_reg;
    st_next.eng_start = 1'b0;
    st_next.rd_valid = 1'b0;
    st_next.rd_last = 1'b0;
    st_next.done = 1'b0;
    st_next.error = 1'b0;
    st_next.start_pin = 1'b0;
    st_next.result_ready_n_prev = result_ready_n_s;
    if (result_ready_n_edge)
    begin
      st_next.since_edge = 16'h0000;
    end
    else if (st_reg.since_edge != 16'hFFFF)
    begin
      st_next.since_edge = st_reg.since_edge + 16'h0001;
    end
    if (result_ready_n_fall)
    begin
      st_next.fall_pend = 1'b1;
    end
    case (st_reg.state)
      ADF_ST_IDLE:
      begin
        if (cmd_valid_in && st_reg.cmd_ready)
        begin
          if (refuse)
          begin
            st_next.error = 1'b1;
          end
          else
          begin
            st_next.op = op_in;
            st_next.addr = cmd_addr_in;
            st_next.cnt = cmd_count_in;
            st_next.byte_idx = 6'h00;
            st_next.tx = first_byte(op_in, cmd_addr_in);
            st_next.opc_bytes = `ADF_OPC_BYTES_ONE;
            st_next.total = 6'h01;
            if (op_in == ADF_OP_REGISTER_READ_CMD || op_in == ADF_OP_REGISTER_WRITE_CMD)
            begin
              st_next.opc_bytes = `ADF_OPC_BYTES_TWO;
              st_next.total = 6'(cmd_count_in) + 6'h03;
            end
            else if (op_in == ADF_OP_RDATA)
            begin
              st_next.total = `ADF_RESULT_BYTES + 6'h01;
            end
            if (op_in == ADF_OP_RDATA || op_in == ADF_OP_CONTINUOUS_READOUT_CMD)
            begin
              st_next.state = ADF_ST_WAIT_RESULT_READY_N;
            end
            else
            begin
              st_next.cs_n = 1'b0;
              st_next.eng_start = 1'b1;
              st_next.state = ADF_ST_SEND;
            end
          end
        end
        else if (st_reg.cont && st_reg.running && go_read)
        begin
          st_next.fall_pend = result_ready_n_fall;
          st_next.op = ADF_OP_AUTO;
          st_next.opc_bytes = 2'h0;
          st_next.total = `ADF_RESULT_BYTES;
          st_next.byte_idx = 6'h00;
          st_next.tx = `ADF_FILL_BYTE;
          st_next.cs_n = 1'b0;
          st_next.eng_start = 1'b1;
          st_next.state = ADF_ST_SEND;
        end
      end
      ADF_ST_WAIT_RESULT_READY_N:
      begin
        if ((st_reg.op == ADF_OP_RDATA && go_read) ||
            (st_reg.op == ADF_OP_CONTINUOUS_READOUT_CMD &&
             st_reg.since_edge >= `ADF_KEEPOUT_CYC))
        begin
          if (st_reg.op == ADF_OP_RDATA)
          begin
            st_next.fall_pend = result_ready_n_fall;
          end
          st_next.cs_n = 1'b0;
          st_next.eng_start = 1'b1;
          st_next.state = ADF_ST_SEND;
        end
      end
      ADF_ST_SEND:
      begin
        if (eng_done)
        begin
          st_next.byte_idx = st_reg.byte_idx + 6'h01;
          if (st_reg.byte_idx >= 6'(st_reg.opc_bytes) &&
              st_reg.op != ADF_OP_REGISTER_WRITE_CMD)
          begin
            // Whole bytes are shifted even past a new data ready
            st_next.rd_data = eng_rx;
            st_next.rd_valid = 1'b1;
            st_next.rd_last = st_reg.byte_idx + 6'h01 == st_reg.total;
          end
          st_next.gap_cnt = 16'h0000;
          if (st_reg.byte_idx + 6'h01 == st_reg.total)
          begin
            st_next.gap_cnt = `ADF_DECODE_CYC;
            if (st_reg.op == ADF_OP_RESET)
            begin
              st_next.gap_cnt = 16'(RESET_WAIT_CYC);
            end
          end
          else if (st_reg.byte_idx < 6'(st_reg.opc_bytes) &&
                   st_reg.op != ADF_OP_RDATA)
          begin
            st_next.gap_cnt = `ADF_DECODE_CYC;
          end
          st_next.state = ADF_ST_GAP;
        end
      end
      ADF_ST_GAP:
      begin
        if (st_reg.gap_cnt != 16'h0000)
        begin
          st_next.gap_cnt = st_reg.gap_cnt - 16'h0001;
        end
        else if (st_reg.byte_idx == st_reg.total)
        begin
          st_next.cs_n = 1'b1;
          st_next.done = st_reg.op != ADF_OP_AUTO;
          st_next.state = ADF_ST_IDLE;
          case (st_reg.op)
            ADF_OP_WAKE: st_next.standby = 1'b0;
            ADF_OP_STANDBY: st_next.standby = 1'b1;
            ADF_OP_RESET:
            begin
              st_next.calib_en = 1'b0;
              st_next.cont = 1'b1;
            end
            ADF_OP_START: st_next.running = 1'b1;
            ADF_OP_STOP: st_next.running = 1'b0;
            ADF_OP_OFFCAL: st_next.cal_need = 1'b0;
            ADF_OP_CONTINUOUS_READOUT_CMD: st_next.cont = 1'b1;
            ADF_OP_HALT_CONTINUOUS_READOUT_CMD: st_next.cont = 1'b0;
            default: st_next.cont = st_reg.cont;
          endcase
        end
        else if (st_reg.op == ADF_OP_REGISTER_WRITE_CMD &&
                 st_reg.byte_idx >= 6'(st_reg.opc_bytes))
        begin
          st_next.wr_ready = 1'b1;
          st_next.state = ADF_ST_WAIT_WR;
        end
        else
        begin
          st_next.tx = `ADF_FILL_BYTE;
          if (st_reg.byte_idx == 6'h01 && st_reg.opc_bytes == 2'h2)
          begin
            st_next.tx = {`ADF_CNT_PFX, st_reg.cnt};
          end
          st_next.eng_start = 1'b1;
          st_next.state = ADF_ST_SEND;
        end
      end
      ADF_ST_WAIT_WR:
      begin
        if (wr_valid_in && st_reg.wr_ready)
        begin
          st_next.wr_ready = 1'b0;
          st_next.tx = wr_data_in;
          if (wr_addr == `ADF_REG_RESPIRATION_CONTROL_TWO)
          begin
            st_next.calib_en = wr_data_in[`ADF_CALIB_BIT];
          end
          if (wr_addr == `ADF_REG_CH1SET || wr_addr == `ADF_REG_CH2SET)
          begin
            st_next.cal_need = 1'b1;
          end
          st_next.eng_start = 1'b1;
          st_next.state = ADF_ST_SEND;
        end
      end
      default:
      begin
        st_next.state = ADF_ST_IDLE;
        st_next.cs_n = 1'b1;
      end
    endcase
    st_next.cmd_ready = st_next.state == ADF_ST_IDLE;
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_reg <= '0;
      st_reg.state <= ADF_ST_IDLE;
      st_reg.op <= ADF_OP_WAKE;
      st_reg.cs_n <= 1'b1;
      st_reg.cmd_ready <= 1'b1;
      st_reg.cont <= 1'b1;
      st_reg.result_ready_n_prev <= `ADF_RESULT_READY_N_IDLE;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign cmd_ready_out = st_reg.cmd_ready;
  assign wr_ready_out = st_reg.wr_ready;
  assign rd_data_out = st_reg.rd_data;
  assign rd_valid_out = st_reg.rd_valid;
  assign rd_last_out = st_reg.rd_last;
  assign done_out = st_reg.done;
  assign error_out = st_reg.error;
  assign standby_out = st_reg.standby;
  assign cont_mode_out = st_reg.cont;
  assign running_out = st_reg.running;
  assign cal_needed_out = st_reg.cal_need;
  assign cs_n_out = st_reg.cs_n;
  assign start_pin_out = st_reg.start_pin;
endmodule

// [adf_host_ctrl_monitor.sv]
// Assertion checker for the front-end command host controller
`timescale 1ns/1ps
module adf_host_ctrl_monitor
  import adf_pkg::*;
#(
  parameter int RESET_WAIT_CYC = 50
)(
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic cmd_valid_in,
  input wire logic [3:0] cmd_code_in,
  input wire logic cmd_ready_out,
  input wire logic rd_valid_out,
  input wire logic rd_last_out,
  input wire logic done_out,
  input wire logic error_out,
  input wire logic standby_out,
  input wire logic cont_mode_out,
  input wire logic running_out,
  input wire logic cs_n_out,
  input wire logic sclk_out,
  input wire logic start_pin_out
);
  localparam int DEC_GAP = 782;
  logic [15:0] quiet_reg;
  logic [3:0] code_reg;
  // Cycles since the serial clock was last high, and the last code taken
  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      quiet_reg <= 16'h0000;
      code_reg <= 4'h0;
    end
    else
    begin
      if (sclk_out)
        quiet_reg <= 16'h0000;
      else if (quiet_reg != 16'hFFFF)
        quiet_reg <= quiet_reg + 16'h0001;
      if (cmd_valid_in && cmd_ready_out)
        code_reg <= cmd_code_in;
    end
  end
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (rst_in);
  sequence take_s;
    cmd_valid_in && cmd_ready_out;
  endsequence
  sequence refused_s;
    error_out ##1 !error_out;
  endsequence
  bad_code_a: assert property (
    take_s and cmd_code_in > 4'hA |=> refused_s)
    else $error("undefined code not refused");
  cont_halt_a: assert property (
    take_s and cont_mode_out && cmd_code_in != 4'h7 |=> refused_s)
    else $error("command other than halt taken in continuous mode");
  standby_wake_a: assert property (
    take_s and standby_out && cmd_code_in != 4'h0 |=> refused_s)
    else $error("command other than wake taken in standby");
  read_running_a: assert property (
    take_s and !running_out && cmd_code_in == 4'h8 |=> refused_s)
    else $error("single read taken while stopped");
  refuse_quiet_a: assert property (error_out |-> cs_n_out [*2])
    else $error("refused command moved chip select");
  done_gap_a: assert property (
    done_out && code_reg < 4'h8 && code_reg != 4'h2 |-> quiet_reg >= DEC_GAP)
    else $error("system command closed before decode time");
  select_idle_a: assert property (cs_n_out |-> !sclk_out)
    else $error("serial clock high while deselected");
  start_low_a: assert property (!start_pin_out)
    else $error("start pin driven high");
  done_frame_a: assert property (done_out |-> cs_n_out ##1 !done_out)
    else $error("done while selected or longer than a cycle");
  last_byte_a: assert property (rd_last_out |-> rd_valid_out)
    else $error("last byte flag without a byte");
endmodule

// [adf_dev_model.sv]
// Behavioural model of the front end's serial command interface
`timescale 1ns/1ps
module adf_dev_model (
  input wire logic clock_in,
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic mosi_in,
  output logic miso_out,
  output logic result_ready_n_out
);
  // Register defaults; the identity byte at 00h is arbitrary
  localparam logic [7:0] DEF [0:11] = '{8'h5A, 8'h02, 8'h80, 8'h10, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h0C};
  logic [7:0] regs [0:11] = DEF;
  logic [7:0] sh = 8'h00, op = 8'h00, last_op = 8'h00, b;
  logic cont = 1'b1, running = 1'b0, standby = 1'b0;
  int nb = 0, dc = 0;
  initial miso_out = 1'b0;
  initial result_ready_n_out = 1'b1;
  function automatic logic rbit(input int n);
    logic [7:0] v;
    v = 8'hC0 + 8'(n / 8);
    return v[7 - n % 8];
  endfunction
  // Bytes taken on falling edges; an opcode acts once complete
  always @(negedge sclk_in or posedge cs_n_in)
  begin
    if (cs_n_in)
    begin
      nb <= 0;
      op <= 8'h00;
    end
    else
    begin
      b = {sh[6:0], mosi_in};
      sh <= b;
      nb <= nb + 1;
      if (nb == 7)
      begin
        op <= b;
        last_op <= b;
        cont <= (b == 8'h10 || b == 8'h06) ? 1'b1 : (b == 8'h11) ? 1'b0 : cont;
        case (b)
          8'h02: standby <= 1'b0;
          8'h04: standby <= 1'b1;
          8'h06: regs <= DEF;
          8'h08: running <= 1'b1;
          8'h0A: running <= 1'b0;
          default: ;
        endcase
      end
      else if (nb >= 23 && nb % 8 == 7 && op[7:5] == 3'h2)
        regs[op[4:0] + 5'((nb - 16) / 8)] <= b;
    end
  end
  // Data out on rising edges; inverted once the select is released
  always @(posedge sclk_in or posedge cs_n_in)
  begin
    if (cs_n_in)
      miso_out <= ~miso_out;
    else if (cont)
      miso_out <= rbit(nb);
    else if (op == 8'h12 && nb >= 8)
      miso_out <= rbit(nb - 8);
    else if (op[7:5] == 3'h1 && nb >= 16)
      miso_out <= regs[op[4:0] + 5'((nb - 16) / 8)][7 - nb % 8];
  end
  // A result every 3000 cycles while converting
  always @(posedge clock_in)
  begin
    dc <= (!running || dc == 2999) ? 0 : dc + 1;
    result_ready_n_out <= !running || dc >= 2900;
  end
endmodule

// [tb_adf_host_ctrl.sv]
// Testbench for the front-end command host controller
`timescale 1ns/1ps
`include "adf_defines.svh"
module tb_adf_host_ctrl;
  localparam int RESET_WAIT_CYC = 50;
  logic clock_in, rst_in, cmd_valid_in, wr_valid_in, miso_in;
  logic result_ready_n_in, cmd_ready_out, wr_ready_out, rd_valid_out;
  logic rd_last_out, done_out, error_out, standby_out, cont_mode_out;
  logic running_out, cal_needed_out, cs_n_out, sclk_out, mosi_out;
  logic start_pin_out;
  logic [3:0] cmd_code_in;
  logic [4:0] cmd_addr_in, cmd_count_in;
  logic [7:0] wr_data_in, rd_data_out;
  logic [7:0] rx[$], exq[$];
  logic [7:0] wbuf [0:1] = '{8'h55, 8'h80};
  int error_cnt = 0, compares = 0, cyc = 0, last_at = 0, wi = 2;
  adf_host_ctrl #(.RESET_WAIT_CYC(RESET_WAIT_CYC)) u_adf_host_ctrl (.*);
  adf_dev_model u_adf_dev_model (.clock_in(clock_in), .cs_n_in(cs_n_out),
    .sclk_in(sclk_out), .mosi_in(mosi_out), .miso_out(miso_in),
    .result_ready_n_out(result_ready_n_in));
  initial
  begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end
  always @(posedge clock_in)
  begin
    cyc = cyc + 1;
    if (wr_valid_in === 1'b1 && wr_ready_out === 1'b1)
      wi = wi + 1;
    wr_valid_in <= (wi < 2);
    wr_data_in <= wbuf[wi[0]];
    if (rd_valid_out === 1'b1)
      rx.push_back(rd_data_out);
    if (rd_valid_out === 1'b1 && rd_last_out === 1'b1)
      last_at = rx.size();
    if (cyc == 90000)
    begin
      error_cnt++;
      test_done();
    end
  end
  task automatic check(input string nm, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic flag(input string nm, input logic seen, exp);
    check(nm, {7'h00, seen}, {7'h00, exp});
  endtask
  task automatic check_rx;
    check("byte count", 8'(rx.size()), 8'(exq.size()));
    check("last flag", 8'(last_at), 8'(exq.size()));
    foreach (exq[i])
      check("read byte", rx[i], exq[i]);
  endtask
  task automatic fill_res;
    exq.delete();
    for (int i = 0; i < 9; i++)
      exq.push_back(8'hC0 + 8'(i));
  endtask
  task automatic cmd(input logic [3:0] c, input logic [4:0] a, n,
    input logic e, input logic [7:0] op);
    rx.delete();
    last_at = 0;
    cmd_code_in <= c;
    cmd_addr_in <= a;
    cmd_count_in <= n;
    cmd_valid_in <= 1'b1;
    do @(posedge clock_in); while (cmd_ready_out !== 1'b1);
    cmd_valid_in <= 1'b0;
    for (int t = 0; t < 9000; t++)
    begin
      @(posedge clock_in);
      if (done_out === 1'b1 || error_out === 1'b1)
        break;
    end
    flag("refused", error_out, e);
    if (!e)
      check("opcode", u_adf_dev_model.last_op, op);
    @(posedge clock_in);
  endtask
  task automatic t_refuse;
    flag("cont at reset", cont_mode_out, 1'b1);
    flag("select idle", cs_n_out, 1'b1);
    cmd(4'h3, 5'h00, 5'h00, 1'b1, 8'h00);
    cmd(4'h9, 5'h00, 5'h00, 1'b1, 8'h00);
    cmd(4'hC, 5'h00, 5'h00, 1'b1, 8'h00);
    check("nothing sent", u_adf_dev_model.last_op, 8'h00);
    $display("t_refuse done");
  endtask
  task automatic t_regs;
    cmd(4'h7, 5'h00, 5'h00, 1'b0, `ADF_OPC_HALT_CONTINUOUS_READOUT_CMD);
    flag("cont off", cont_mode_out, 1'b0);
    cmd(4'h5, 5'h00, 5'h00, 1'b1, 8'h00);
    wi = 0;
    cmd(4'hA, 5'h09, 5'h01, 1'b0, {`ADF_REGISTER_WRITE_CMD_PFX, 5'h09});
    check("reg 09h", u_adf_dev_model.regs[9], 8'h55);
    check("reg 0Ah", u_adf_dev_model.regs[10], 8'h80);
    flag("no cal", cal_needed_out, 1'b0);
    wi = 1;
    cmd(4'hA, 5'h04, 5'h00, 1'b0, {`ADF_REGISTER_WRITE_CMD_PFX, 5'h04});
    check("reg 04h", u_adf_dev_model.regs[4], 8'h80);
    flag("cal needed", cal_needed_out, 1'b1);
    cmd(4'h9, 5'h08, 5'h02, 1'b0, {`ADF_REGISTER_READ_CMD_PFX, 5'h08});
    exq = '{8'h00, 8'h55, 8'h80};
    check_rx();
    cmd(4'h5, 5'h00, 5'h00, 1'b0, `ADF_OPC_OFFCAL);
    flag("cal cleared", cal_needed_out, 1'b0);
    $display("t_regs done");
  endtask
  task automatic t_conv;
    cmd(4'h8, 5'h00, 5'h00, 1'b1, 8'h00);
    cmd(4'h3, 5'h00, 5'h00, 1'b0, `ADF_OPC_START);
    cmd(4'h3, 5'h00, 5'h00, 1'b0, `ADF_OPC_START);
    flag("running", running_out, 1'b1);
    cmd(4'h8, 5'h00, 5'h00, 1'b0, `ADF_OPC_RDATA);
    fill_res();
    check_rx();
    cmd(4'h6, 5'h00, 5'h00, 1'b0, `ADF_OPC_CONTINUOUS_READOUT_CMD);
    for (int t = 0; t < 9000 && rx.size() < 9; t++)
      @(posedge clock_in);
    check_rx();
    cmd(4'h7, 5'h00, 5'h00, 1'b0, `ADF_OPC_HALT_CONTINUOUS_READOUT_CMD);
    cmd(4'h4, 5'h00, 5'h00, 1'b0, `ADF_OPC_STOP);
    flag("stopped", running_out, 1'b0);
    $display("t_conv done");
  endtask
  task automatic t_power;
    cmd(4'h1, 5'h00, 5'h00, 1'b0, `ADF_OPC_STANDBY);
    flag("standby", standby_out, 1'b1);
    cmd(4'h3, 5'h00, 5'h00, 1'b1, 8'h00);
    cmd(4'h0, 5'h00, 5'h00, 1'b0, `ADF_OPC_WAKE);
    flag("awake", standby_out, 1'b0);
    cmd(4'h2, 5'h00, 5'h00, 1'b0, `ADF_OPC_RESET);
    flag("cont after reset", cont_mode_out, 1'b1);
    check("reg default", u_adf_dev_model.regs[10], 8'h02);
    $display("t_power done");
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    rst_in = 1'b1;
    cmd_valid_in = 1'b0;
    cmd_code_in = 4'h0;
    cmd_addr_in = 5'h00;
    cmd_count_in = 5'h00;
    repeat (20) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    t_refuse();
    t_regs();
    t_conv();
    t_power();
    test_done();
  end
endmodule
bind adf_host_ctrl adf_host_ctrl_monitor #(.RESET_WAIT_CYC(RESET_WAIT_CYC))
  u_mon (.*);
